// ### src/vgast_pkg.sv
package vgast_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int COLOUR_W  = 8;
    localparam int CNT_W     = 12;
    localparam int MODE_W    = 4;
    localparam int MODES     = 9;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        PH_SYNC,
        PH_BACK,
        PH_DISP,
        PH_FRONT
    } vgast_phase_t;

    typedef enum logic [3:0] {
        M640_60,
        M640_85,
        M800_60,
        M800_75,
        M800_85,
        M1024_60,
        M1024_70,
        M1024_85,
        M1280_60
    } vgast_mode_t;

    typedef struct packed {
        logic [COLOUR_W-1:0] red;
        logic [COLOUR_W-1:0] green;
        logic [COLOUR_W-1:0] blue;
    } vgast_rgb_t;

    localparam int RGB_W = 3 * COLOUR_W;

    // ****************************************
    // Reset values
    // ****************************************
    localparam vgast_mode_t  MODE_RST  = M640_60;
    localparam vgast_phase_t PHASE_RST = PH_SYNC;
    localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
    localparam vgast_rgb_t   RGB_OFF   = '0;

    // ****************************************
    // Horizontal times, unit 100 ns
    // ****************************************
    localparam int H_SYNC_T100NS [MODES] =
        '{38, 16, 32, 16, 11, 21, 18, 10, 10};
    localparam int H_BACK_T100NS [MODES] =
        '{19, 22, 22, 32, 27, 25, 19, 22, 23};
    localparam int H_DISP_T100NS [MODES] =
        '{254, 178, 200, 162, 142, 158, 137, 108, 119};
    localparam int H_FRONT_T100NS [MODES] =
        '{6, 16, 10, 3, 6, 4, 3, 5, 4};
    localparam int PIX_MHZ [MODES] =
        '{25, 36, 40, 49, 56, 65, 75, 95, 108};
    localparam int T100NS_PER_US = 10;

    // ****************************************
    // Vertical periods, unit lines
    // ****************************************
    localparam int V_SYNC_LINES [MODES] =
        '{2, 3, 4, 3, 3, 6, 6, 3, 3};
    localparam int V_BACK_LINES [MODES] =
        '{33, 25, 23, 21, 27, 29, 29, 36, 38};
    localparam int V_DISP_LINES [MODES] =
        '{480, 480, 600, 600, 600, 768, 768, 768, 1024};
    localparam int V_FRONT_LINES [MODES] =
        '{10, 1, 1, 1, 1, 3, 3, 1, 1};

    // Time in 100 ns units to whole pixel clocks, rounded up
    function automatic logic [CNT_W-1:0] t_to_cyc(input int t,
                                                 input int mhz);
        int c;
        c = (t * mhz + T100NS_PER_US - 1) / T100NS_PER_US;
        if (c < 1) begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction

endpackage

// ### src/vgast_top.sv
// Behaviour
// - Hsync low for mode width each row
// - Colour zero during back porch
// - One pixel per clock in display
// - Colour zero during front porch
// - Vsync same sequence counted in rows
// - 640x480 60 Hz timing
// - 640x480 85 Hz timing
// - 800x600 60 Hz timing
// - 800x600 75 Hz timing
// - 800x600 85 Hz timing
// - 1024x768 60 Hz timing
// - 1024x768 70 Hz timing
// - 1024x768 85 Hz timing
// - 1280x1024 60 Hz timing
// - Eight bit colour to upper inputs

// ****************************************
// Dual clock FIFO
// ****************************************
module vgast_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             wr_clk,
    input  wire logic             wr_reset_n,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_clk,
    input  wire logic             rd_reset_n,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wbin_q;
    logic [AW:0]      wgray_q;
    logic [AW:0]      rbin_q;
    logic [AW:0]      rgray_q;
    logic [AW:0]      rg_s1_q;
    logic [AW:0]      rg_s2_q;
    logic [AW:0]      wg_s1_q;
    logic [AW:0]      wg_s2_q;
    logic [AW:0]      wbin_d;
    logic [AW:0]      rbin_d;
    logic             wr_fire;
    logic             rd_fire;

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    assign wr_ready = wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]};
    assign rd_valid = rgray_q != wg_s2_q;
    assign wr_fire  = wr_valid && wr_ready;
    assign rd_fire  = rd_valid && rd_ready;
    assign wbin_d   = wbin_q + (AW+1)'(1);
    assign rbin_d   = rbin_q + (AW+1)'(1);
    assign rd_data  = mem_q[rbin_q[AW-1:0]];

    // ****************************************
    // Write side
    // ****************************************
    always_ff @(posedge wr_clk) begin
        if (wr_fire) begin
            mem_q[wbin_q[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge wr_clk or negedge wr_reset_n) begin
        if (!wr_reset_n) begin
            wbin_q  <= '0;
            wgray_q <= '0;
        end else if (wr_fire) begin
            wbin_q  <= wbin_d;
            wgray_q <= bin2gray(wbin_d);
        end
    end

    always_ff @(posedge wr_clk or negedge wr_reset_n) begin
        if (!wr_reset_n) begin
            rg_s1_q <= '0;
            rg_s2_q <= '0;
        end else begin
            rg_s1_q <= rgray_q;
            rg_s2_q <= rg_s1_q;
        end
    end

    // ****************************************
    // Read side
    // ****************************************
    always_ff @(posedge rd_clk or negedge rd_reset_n) begin
        if (!rd_reset_n) begin
            rbin_q  <= '0;
            rgray_q <= '0;
        end else if (rd_fire) begin
            rbin_q  <= rbin_d;
            rgray_q <= bin2gray(rbin_d);
        end
    end

    always_ff @(posedge rd_clk or negedge rd_reset_n) begin
        if (!rd_reset_n) begin
            wg_s1_q <= '0;
            wg_s2_q <= '0;
        end else begin
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
        end
    end
endmodule

// ****************************************
// Raster timing generator
// ****************************************
module vgast_top
    import vgast_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              pixel_valid,
    output logic                   pixel_ready,
    input  wire vgast_rgb_t        pixel_data,
    output logic                   frame_start,
    output logic                   underrun,
    input  wire logic              pix_clk,
    input  wire logic [MODE_W-1:0] mode_sel,
    output logic                   horizontal_sync_out,
    output logic                   vertical_sync_out,
    output vgast_rgb_t             colour_out,
    output logic                   dac_clk,
    output logic                   dac_blank_n,
    output logic                   dac_sync_n
);

    // ****************************************
    // Pixel clock domain reset and mode capture
    // ****************************************
    logic [1:0]        prst_q;
    logic              prst_n;
    logic [MODE_W-1:0] mode_s1_q;
    logic [MODE_W-1:0] mode_s2_q;
    vgast_mode_t       mode_q;
    vgast_mode_t       mode_d;

    always_ff @(posedge pix_clk or negedge reset_n) begin
        if (!reset_n) begin
            prst_q <= 2'h0;
        end else begin
            prst_q <= {prst_q[0], 1'b1};
        end
    end

    assign prst_n = prst_q[1];

    always_ff @(posedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            mode_s1_q <= '0;
            mode_s2_q <= '0;
        end else begin
            mode_s1_q <= mode_sel;
            mode_s2_q <= mode_s1_q;
        end
    end

    always_comb begin
        mode_d = MODE_RST;
        if (int'(mode_s2_q) < MODES) begin
            mode_d = vgast_mode_t'(mode_s2_q);
        end
    end

    // ****************************************
    // Period lookup
    // ****************************************
    // mode table lookup
    function automatic logic [CNT_W-1:0] h_len(input vgast_mode_t m,
                                               input vgast_phase_t p);
        int i;
        i = int'(m);
        case (p)
            PH_SYNC:  return t_to_cyc(H_SYNC_T100NS[i], PIX_MHZ[i]);
            PH_BACK:  return t_to_cyc(H_BACK_T100NS[i], PIX_MHZ[i]);
            PH_DISP:  return t_to_cyc(H_DISP_T100NS[i], PIX_MHZ[i]);
            PH_FRONT: return t_to_cyc(H_FRONT_T100NS[i], PIX_MHZ[i]);
            default:  return CNT_RST;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] v_len(input vgast_mode_t m,
                                               input vgast_phase_t p);
        int i;
        i = int'(m);
        case (p)
            PH_SYNC:  return CNT_W'(V_SYNC_LINES[i]);
            PH_BACK:  return CNT_W'(V_BACK_LINES[i]);
            PH_DISP:  return CNT_W'(V_DISP_LINES[i]);
            PH_FRONT: return CNT_W'(V_FRONT_LINES[i]);
            default:  return CNT_RST;
        endcase
    endfunction

    function automatic vgast_phase_t next_phase(input vgast_phase_t p);
        case (p)
            PH_SYNC:  return PH_BACK;
            PH_BACK:  return PH_DISP;
            PH_DISP:  return PH_FRONT;
            PH_FRONT: return PH_SYNC;
            default:  return PH_SYNC;
        endcase
    endfunction

    // ****************************************
    // Horizontal counter
    // ****************************************
    vgast_phase_t     h_phase_q;
    logic [CNT_W-1:0] h_cnt_q;
    logic             h_last;
    logic             row_end;

    assign h_last  = h_cnt_q == h_len(mode_q, h_phase_q) - CNT_W'(1);
    assign row_end = h_last && (h_phase_q == PH_FRONT);

    always_ff @(posedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            h_phase_q <= PHASE_RST;
            h_cnt_q   <= CNT_RST;
        end else if (h_last) begin
            h_phase_q <= next_phase(h_phase_q);
            h_cnt_q   <= CNT_RST;
        end else begin
            h_cnt_q   <= h_cnt_q + CNT_W'(1);
        end
    end

    // ****************************************
    // Vertical counter
    // ****************************************
    vgast_phase_t     v_phase_q;
    logic [CNT_W-1:0] v_cnt_q;
    logic             v_last;
    logic             frame_end;

    assign v_last    = v_cnt_q == v_len(mode_q, v_phase_q) - CNT_W'(1);
    assign frame_end = row_end && v_last && (v_phase_q == PH_FRONT);

    always_ff @(posedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            v_phase_q <= PHASE_RST;
            v_cnt_q   <= CNT_RST;
        end else if (row_end) begin
            if (v_last) begin
                v_phase_q <= next_phase(v_phase_q);
                v_cnt_q   <= CNT_RST;
            end else begin
                v_cnt_q   <= v_cnt_q + CNT_W'(1);
            end
        end
    end

    // Mode changes only between frames
    always_ff @(posedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            mode_q <= MODE_RST;
        end else if (frame_end) begin
            mode_q <= mode_d;
        end
    end

    // ****************************************
    // Pixel buffer
    // ****************************************
    logic       disp;
    logic       fifo_valid;
    vgast_rgb_t fifo_data;

    assign disp = (h_phase_q == PH_DISP) && (v_phase_q == PH_DISP);

    vgast_fifo #(
        .WIDTH (RGB_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .wr_clk     (clk),
        .wr_reset_n (reset_n),
        .wr_valid   (pixel_valid),
        .wr_ready   (pixel_ready),
        .wr_data    (pixel_data),
        .rd_clk     (pix_clk),
        .rd_reset_n (prst_n),
        .rd_valid   (fifo_valid),
        .rd_ready   (disp),
        .rd_data    (fifo_data)
    );

    // ****************************************
    // Video outputs
    // ****************************************
    logic       hs_q;
    logic       vs_q;
    logic       blank_n_q;
    vgast_rgb_t rgb_q;

    always_ff @(posedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            hs_q <= 1'b1;
            vs_q <= 1'b1;
        end else begin
            hs_q <= h_phase_q != PH_SYNC;
            vs_q <= v_phase_q != PH_SYNC;
        end
    end

    always_ff @(posedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            rgb_q     <= RGB_OFF;
            blank_n_q <= 1'b0;
        end else begin
            blank_n_q <= disp;
            if (disp && fifo_valid) begin
                rgb_q <= fifo_data;
            end else begin
                rgb_q <= RGB_OFF;
            end
        end
    end

    assign colour_out          = rgb_q;
    assign horizontal_sync_out = hs_q;
    assign vertical_sync_out   = vs_q;
    assign dac_blank_n         = blank_n_q;
    assign dac_clk             = pix_clk;
    assign dac_sync_n          = 1'b1;

    // ****************************************
    // Status toward system clock
    // ****************************************
    logic       fs_tog_q;
    logic       urun_q;
    logic [2:0] fs_sync_q;
    logic [1:0] ur_sync_q;
    logic       fs_pulse_q;

    always_ff @(posedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            fs_tog_q <= 1'b0;
        end else if (frame_end) begin
            fs_tog_q <= ~fs_tog_q;
        end
    end

    // Underrun flag, a new miss wins over the frame clear
    always_ff @(posedge pix_clk or negedge prst_n) begin
        if (!prst_n) begin
            urun_q <= 1'b0;
        end else if (disp && !fifo_valid) begin
            urun_q <= 1'b1;
        end else if (frame_end) begin
            urun_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fs_sync_q <= 3'h0;
            ur_sync_q <= 2'h0;
        end else begin
            fs_sync_q <= {fs_sync_q[1:0], fs_tog_q};
            ur_sync_q <= {ur_sync_q[0], urun_q};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fs_pulse_q <= 1'b0;
        end else begin
            fs_pulse_q <= fs_sync_q[2] ^ fs_sync_q[1];
        end
    end

    assign frame_start = fs_pulse_q;
    assign underrun    = ur_sync_q[1];

endmodule

// ### tb/tb.sv
`define CHK(nm, ex, got) \
    begin \
        compares++; \
        if ((got) !== (ex)) begin \
            failures++; \
            $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
        end \
    end

module tb;
    import vgast_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset_n, pixel_valid, pixel_ready, frame_start, underrun;
    logic pix_clk, hs, vs, dac_clk, dac_blank_n, dac_sync_n;
    logic [MODE_W-1:0] mode_sel;
    vgast_rgb_t pixel_data, colour_out;
    int failures, compares, fs_n;

    vgast_top DUT (
        .clk(clk), .reset_n(reset_n), .pixel_valid(pixel_valid),
        .pixel_ready(pixel_ready), .pixel_data(pixel_data),
        .frame_start(frame_start), .underrun(underrun), .pix_clk(pix_clk),
        .mode_sel(mode_sel), .horizontal_sync_out(hs),
        .vertical_sync_out(vs), .colour_out(colour_out),
        .dac_clk(dac_clk), .dac_blank_n(dac_blank_n),
        .dac_sync_n(dac_sync_n)
    );
    vgast_dac_model mon (
        .dac_clk(dac_clk), .reset_n(reset_n), .hs(hs), .vs(vs),
        .blank_n(dac_blank_n), .colour(colour_out)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic int cyc(input int t, input int m);
        return (t * m + 9) / 10;
    endfunction
    function automatic vgast_rgb_t pat(input int i);
        vgast_rgb_t p;
        p.red   = 8'h20 + 8'(i);
        p.green = 8'hA0 - 8'(i);
        p.blue  = 8'h5A ^ 8'(i);
        return p;
    endfunction
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_fill();
        @(posedge clk);
        #1 `CHK("ready_idle", 1'b1, pixel_ready)
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            pixel_valid <= 1'b1;
            pixel_data  <= pat(i);
        end
        @(posedge clk);
        pixel_valid <= 1'b0;
        #1 `CHK("ready_full", 1'b0, pixel_ready)
    endtask
    task automatic t_pixels();
        for (int k = 0; k < 10000 && mon.pix_n < 9; k++) @(posedge clk);
        `CHK("pix_wait", 1'b1, mon.pix_n >= 9)
        for (int i = 0; i < 8; i++) `CHK("pixel", pat(i), mon.pix[i])
        `CHK("pixel_under", RGB_OFF, mon.pix[8])
        @(posedge clk);
        #1 `CHK("underrun", 1'b1, underrun)
        @(posedge pix_clk);
        #1 `CHK("dac_clk_hi", 1'b1, dac_clk)
        @(negedge pix_clk);
        #1 `CHK("dac_clk_lo", 1'b0, dac_clk)
    endtask
    task automatic t_row(input int m);
        int hs_e, bp_e, de_e, fp_e;
        hs_e = cyc(H_SYNC_T100NS[m], PIX_MHZ[m]);
        bp_e = cyc(H_BACK_T100NS[m], PIX_MHZ[m]);
        de_e = cyc(H_DISP_T100NS[m], PIX_MHZ[m]);
        fp_e = cyc(H_FRONT_T100NS[m], PIX_MHZ[m]);
        for (int k = 0; k < 20000 && mon.disp_rows < 1; k++) @(posedge clk);
        `CHK("row_wait", 1'b1, mon.disp_rows >= 1)
        `CHK("hs_w", hs_e, mon.hs_w)
        `CHK("bp_w", bp_e, mon.bp_w)
        `CHK("de_w", de_e, mon.de_w)
        `CHK("fp_w", fp_e, mon.fp_w)
        `CHK("row_w", hs_e + bp_e + de_e + fp_e, mon.row_w)
        `CHK("vs_rows", V_SYNC_LINES[m], mon.vs_rows)
        `CHK("vbp_rows", V_BACK_LINES[m], mon.vbp_w)
    endtask
    task automatic t_frame();
        @(posedge clk);
        mode_sel <= 4'h8;
        for (int k = 0; k < 70000 && mon.frames < 2; k++) @(posedge clk);
        `CHK("frame_wait", 1'b1, mon.frames >= 2)
        repeat (10) @(posedge clk);
        `CHK("frame_rows", V_DISP_LINES[0], mon.frame_rows)
        `CHK("frame_start", 1, fs_n)
        `CHK("underrun_clr", 1'b0, underrun)
    endtask

    // ****************************************
    // Clocks, reset and sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        pix_clk = 1'b0;
        #1.3;
        forever #3 pix_clk = ~pix_clk;
    end
    always @(posedge clk) begin
        if (frame_start === 1'b1) fs_n++;
    end
    initial begin
        #3_500_000;
        failures++;
        test_done();
    end
    initial begin
        {reset_n, pixel_valid, failures, compares, fs_n} = '0;
        pixel_data = RGB_OFF;
        mode_sel = 4'h0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_fill();
        t_pixels();
        t_row(0);
        t_frame();
        t_row(8);
        test_done();
    end
endmodule

// ### tb/vgast_dac_model.sv
module vgast_dac_model
    import vgast_pkg::*;
(
    input wire logic       dac_clk,
    input wire logic       reset_n,
    input wire logic       hs,
    input wire logic       vs,
    input wire logic       blank_n,
    input wire vgast_rgb_t colour
);
    timeunit 1ns;
    timeprecision 100ps;
    int t, hs_w, bp_w, de_w, fp_w, row_w, de_end, vsn, vs_rows;
    int vbp, vbp_w, disp_rows, frame_rows, frames, pix_n;
    logic hs_q, vs_q, bl_q, had_de;
    vgast_rgb_t pix [9];
    logic [9:0] dac_red;

    // ****************************************
    // Converter and monitor
    // ****************************************
    // Upper eight inputs
    assign dac_red = {colour.red, 2'b00};
    always @(posedge dac_clk or negedge reset_n) begin
        if (!reset_n) begin
            {hs_q, vs_q, bl_q, had_de} = 4'h0 | 4'hC;
            {t, frames, pix_n, disp_rows, vsn, vbp} = '0;
        end else begin
            t = t + 1;
            if (!vs && vs_q) begin
                frames++;
                frame_rows = disp_rows;
                disp_rows = 0;
                vsn = 0;
            end
            if (vs && !vs_q) begin
                vs_rows = vsn;
                vbp = 0;
            end
            if (!hs && hs_q) begin
                row_w = t;
                if (had_de) begin
                    fp_w = t - de_end;
                    disp_rows++;
                end
                had_de = 0;
                if (!vs) vsn++;
                else vbp++;
                t = 0;
            end
            if (hs && !hs_q) hs_w = t;
            if (blank_n && !bl_q) begin
                bp_w = t - hs_w;
                if (disp_rows == 0) vbp_w = vbp - 1;
                had_de = 1;
            end
            if (!blank_n && bl_q) begin
                de_w = t - hs_w - bp_w;
                de_end = t;
            end
            if (blank_n && pix_n < 9) begin
                pix[pix_n] = colour;
                pix[pix_n].red = dac_red[9:2];
                pix_n++;
            end
            {hs_q, vs_q, bl_q} = {hs, vs, blank_n};
        end
    end
endmodule

// ### tb/vgast_top_props.sv
module vgast_top_props
    import vgast_pkg::*;
(
    input wire logic       reset_n,
    input wire logic       pix_clk,
    input wire logic       horizontal_sync_out,
    input wire logic       vertical_sync_out,
    input wire vgast_rgb_t colour_out,
    input wire logic       dac_blank_n,
    input wire logic       dac_sync_n
);
    localparam int HS_MIN = 58;
    localparam int HS_MAX = 137;
    localparam int DE_MIN = 635;
    localparam int DE_MAX = 1286;
    logic [CNT_W-1:0] hs_lo_q;
    logic [CNT_W-1:0] de_q;

    default clocking cb @(posedge pix_clk); endclocking
    default disable iff (!reset_n);

    // ****************************************
    // Width counters
    // ****************************************
    always_ff @(posedge pix_clk or negedge reset_n) begin
        if (!reset_n) begin
            hs_lo_q <= '0;
            de_q    <= '0;
        end else begin
            hs_lo_q <= horizontal_sync_out ? '0 : hs_lo_q + CNT_W'(1);
            de_q    <= dac_blank_n ? de_q + CNT_W'(1) : '0;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    sequence s_back;
        !dac_blank_n [*8];
    endsequence
    sequence s_front;
        (horizontal_sync_out && !dac_blank_n) [*8];
    endsequence
    property p_hs_width;
        $rose(horizontal_sync_out) |-> hs_lo_q >= HS_MIN && hs_lo_q <= HS_MAX;
    endproperty
    property p_de_width;
        $fell(dac_blank_n) |-> de_q >= DE_MIN && de_q <= DE_MAX;
    endproperty
    property p_back;
        $rose(horizontal_sync_out) |-> s_back;
    endproperty
    property p_front;
        $fell(dac_blank_n) |-> s_front;
    endproperty
    property p_colour_off;
        !dac_blank_n |-> colour_out == RGB_OFF;
    endproperty
    property p_hs_blank;
        !horizontal_sync_out || !vertical_sync_out |-> !dac_blank_n;
    endproperty
    property p_vs_hs;
        $fell(vertical_sync_out) |-> !horizontal_sync_out;
    endproperty
    property p_sync_n;
        dac_sync_n;
    endproperty
    a_hs_width: assert property (p_hs_width)
        else $error("hsync pulse width out of range");
    a_de_width: assert property (p_de_width)
        else $error("display width out of range");
    a_back: assert property (p_back)
        else $error("back porch not blank");
    a_front: assert property (p_front)
        else $error("front porch too short");
    a_colour_off: assert property (p_colour_off)
        else $error("colour not zero while blank");
    a_hs_blank: assert property (p_hs_blank)
        else $error("blank not low in sync");
    a_vs_hs: assert property (p_vs_hs)
        else $error("vsync not on row boundary");
    a_sync_n: assert property (p_sync_n)
        else $error("composite sync active");
endmodule

bind vgast_top vgast_top_props u_props (
    .reset_n(reset_n), .pix_clk(pix_clk),
    .horizontal_sync_out(horizontal_sync_out),
    .vertical_sync_out(vertical_sync_out), .colour_out(colour_out),
    .dac_blank_n(dac_blank_n), .dac_sync_n(dac_sync_n)
);
